// *** cswm_top.sv ***
// selective wake transceiver mode mapper with wishbone register slave
// What this block does
// - sleep allows only off, wake_capable, selective_wake
// - wake frame: restart, clear config valid, keep 101
// - sleep entry automatically re-arms the transceiver
// - off codes stay off in sleep, unchanged
// - codes 001..011 into sleep become 001
// - codes 101..111 into sleep become 101
// - after restart only off, wake_capable or selective
// - normal restart: off stays, 001..011 become 001
// - normal restart from selective: 101, error set
// - wake_capable sleep restart on pattern sets wake, pattern flags
// - frame wake sets wake, frame, maybe pattern
// - counter overflow sets error, wake, count 100000
// - other wake from selective sleep sets error only
// - fail-safe forces wake_capable without selective wake
// - mode code decode table
// - mode writes accepted only in normal mode
//
// The register addresses and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "cswm_map.svh"
module cswm_top (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // system mode requests, one-cycle pulses
   input wire logic go_normal_i,
   input wire logic go_stop_i,
   input wire logic go_sleep_i,
   input wire logic go_restart_i,
   input wire logic go_failsafe_i,
   // wake events, one-cycle pulses
   input wire logic wake_pattern_i,
   input wire logic wake_frame_i,
   input wire logic frame_in_silence_i,
   input wire logic frame_error_count_overflow_i,
   input wire logic other_wake_i,
   // transceiver state, system mode and interrupt
   output logic [2:0] xcvr_mode_o,
   output logic xcvr_rearm_o,
   output logic [2:0] sbc_mode_o,
   output logic irq_o
);
   cswm_pkg::cswm_sbc_type sbc_reg;
   cswm_pkg::cswm_xcvr_type xcvr_reg;
   cswm_pkg::cswm_xcvr_type dec_mode;
   logic [2:0] code_reg;
   logic cfg_valid_reg, err_reg, bus_wake_reg, pat_reg, frm_reg;
   logic [5:0] frame_error_count_reg;
   logic [`CSWM_IRQ_W-1:0] irq_stat_reg, irq_mask_reg;
   logic [31:0] rdata;
   logic ack_reg, rearm_reg, irq_reg;
   // ************
   // bus decode
   // ************
   // taken while ack is low; a write commits at the edge where ack is seen high
   wire req = cyc_i & stb_i & ~ack_reg;
   wire wr = cyc_i & stb_i & ack_reg & we_i & sel_i[0];
   wire wr_ctrl = wr & (adr_i == `CSWM_OFF_CTRL);
   wire wr_stat = wr & (adr_i == `CSWM_OFF_STAT);
   wire wr_irq = wr & (adr_i == `CSWM_OFF_IRQ);
   wire wr_mask = wr & (adr_i == `CSWM_OFF_MASK);
   // ************
   // system mode decode
   // ************
   wire in_normal = (sbc_reg == cswm_pkg::SBC_NORMAL);
   wire code_wr = wr_ctrl & in_normal & (dat_i[2:0] != code_reg);
   wire sel_swk = code_reg[2] & (code_reg[1:0] != 2'b00);
   wire is_off = (code_reg[1:0] == 2'b00);
   wire sleep_swk = (xcvr_reg == cswm_pkg::XCVR_SWK);
   wire in_sleep = (sbc_reg == cswm_pkg::SBC_SLEEP);
   wire sleep_enter = go_sleep_i & in_normal;
   wire restart_enter = go_restart_i & in_normal;
   wire fs_enter = go_failsafe_i;
   // wake inputs only matter while asleep
   wire wake_any = in_sleep & (wake_pattern_i | wake_frame_i | frame_error_count_overflow_i | other_wake_i);
   wire frame_wake = in_sleep & sleep_swk & wake_frame_i;
   wire ovf_wake = in_sleep & sleep_swk & ~wake_frame_i & frame_error_count_overflow_i;
   wire pat_wake = in_sleep & ~sleep_swk & (xcvr_reg == cswm_pkg::XCVR_WK) & wake_pattern_i;
   // ************
   // interrupt events
   // ************
   // a bus wake only counts while no earlier one is pending
   wire ev_bus_wake = ~bus_wake_reg & (frame_wake | ovf_wake | pat_wake);
   wire ev_sleep = sleep_enter;
   wire ev_restart = restart_enter | wake_any;
   wire ev_failsafe = fs_enter;
   wire [`CSWM_IRQ_W-1:0] irq_ev = {ev_failsafe, ev_restart, ev_sleep, ev_bus_wake};
   // ************
   // mode code decode
   // ************
   // code decode, error flag suppresses selective wake
   always_comb begin
      unique case (code_reg)
         3'b001: dec_mode = cswm_pkg::XCVR_WK;
         3'b010: dec_mode = cswm_pkg::XCVR_RXO;
         3'b011: dec_mode = cswm_pkg::XCVR_NORM;
         3'b101: dec_mode = err_reg ? cswm_pkg::XCVR_WK : cswm_pkg::XCVR_SWK;
         3'b110: dec_mode = err_reg ? cswm_pkg::XCVR_RXO : cswm_pkg::XCVR_RXO_SWK;
         3'b111: dec_mode = err_reg ? cswm_pkg::XCVR_NORM : cswm_pkg::XCVR_NORM_SWK;
         default: dec_mode = cswm_pkg::XCVR_OFF;
      endcase
   end
   // ************
   // read words
   // ************
   wire [31:0] rd_ctrl = {29'h0, code_reg};
   wire [5:0] stat_flags = {frm_reg, pat_reg, bus_wake_reg, err_reg, cfg_valid_reg, 1'b0};
   wire [31:0] rd_stat = {16'h0, 2'b00, frame_error_count_reg, 1'b0, stat_flags, 1'b0};
   wire [31:0] rd_irq = {28'h0, irq_stat_reg};
   wire [31:0] rd_mask = {28'h0, irq_mask_reg};
   assign rdata = (adr_i == `CSWM_OFF_CTRL) ? rd_ctrl :
                  (adr_i == `CSWM_OFF_STAT) ? rd_stat :
                  (adr_i == `CSWM_OFF_IRQ) ? rd_irq :
                  (adr_i == `CSWM_OFF_MASK) ? rd_mask : 32'h0000_0000;
   // ************
   // bus answer
   // ************
   always_ff @(posedge clk_i) begin
      ack_reg <= rst_i ? 1'b0 : req;
   end
   // read data is captured at the take and stands through the ack cycle
   always_ff @(posedge clk_i) begin
      dat_o <= rst_i ? 32'h0000_0000 : (req ? rdata : dat_o);
   end
   // ************
   // system mode and mode bits
   // ************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sbc_reg <= cswm_pkg::SBC_NORMAL;
         code_reg <= `CSWM_CODE_OFF0;
         xcvr_reg <= cswm_pkg::XCVR_OFF;
         err_reg <= 1'b0;
         cfg_valid_reg <= 1'b0;
         rearm_reg <= 1'b0;
      end else begin
         // any entry to sleep re-arms, so a woken transceiver cannot lock up
         rearm_reg <= sleep_enter | code_wr;
         if (fs_enter) begin
            sbc_reg <= cswm_pkg::SBC_FAILSAFE;
            xcvr_reg <= cswm_pkg::XCVR_WK;
         end else if (sleep_enter) begin
            // the code is rewritten so a read shows the mode in force
            sbc_reg <= cswm_pkg::SBC_SLEEP;
            if (is_off) begin
               xcvr_reg <= cswm_pkg::XCVR_OFF;
            end else if (!code_reg[2]) begin
               code_reg <= `CSWM_CODE_WK;
               xcvr_reg <= cswm_pkg::XCVR_WK;
            end else begin
               code_reg <= `CSWM_CODE_SWK;
               xcvr_reg <= err_reg ? cswm_pkg::XCVR_WK : cswm_pkg::XCVR_SWK;
            end
         end else if (restart_enter) begin
            // a restart out of normal never keeps selective wake active
            sbc_reg <= cswm_pkg::SBC_RESTART;
            if (is_off) begin
               xcvr_reg <= cswm_pkg::XCVR_OFF;
            end else if (!sel_swk) begin
               code_reg <= `CSWM_CODE_WK;
               xcvr_reg <= cswm_pkg::XCVR_WK;
               err_reg <= 1'b0;
            end else begin
               code_reg <= `CSWM_CODE_SWK;
               xcvr_reg <= cswm_pkg::XCVR_WK;
               err_reg <= 1'b1;
            end
         end else if (wake_any) begin
            sbc_reg <= cswm_pkg::SBC_RESTART;
            if (frame_wake) begin
               cfg_valid_reg <= 1'b0;
               err_reg <= 1'b0;
            end else if (sleep_swk) begin
               err_reg <= 1'b1;
               xcvr_reg <= cswm_pkg::XCVR_WK;
            end
         end else begin
            if (go_normal_i && sbc_reg != cswm_pkg::SBC_FAILSAFE) begin
               sbc_reg <= cswm_pkg::SBC_NORMAL;
            end else if (go_stop_i && in_normal) begin
               sbc_reg <= cswm_pkg::SBC_STOP;
            end
            if (code_wr) begin
               // config valid survives a mode change
               code_reg <= dat_i[2:0];
            end
            if (in_normal) begin
               xcvr_reg <= dec_mode;
            end
            if (wr_stat && in_normal && sel_i[0]) begin
               if (dat_i[2]) begin
                  cfg_valid_reg <= 1'b1;
               end
               if (dat_i[3]) begin
                  err_reg <= 1'b0;
               end
            end
         end
      end
   end
   // ************
   // wake flags
   // ************
   // frame wake outranks overflow, overflow outranks a plain pattern
   wire flag_clr = wr_stat & dat_i[4];
   wire pat_seen = in_sleep & ~sleep_swk & wake_pattern_i;
   wire xcvr_live = (xcvr_reg != cswm_pkg::XCVR_OFF);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_wake_reg <= 1'b0;
      end else if (frame_wake | ovf_wake) begin
         bus_wake_reg <= 1'b1;
      end else if (pat_seen) begin
         bus_wake_reg <= xcvr_live;
      end else if (flag_clr) begin
         bus_wake_reg <= 1'b0;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pat_reg <= 1'b0;
      end else if (frame_wake) begin
         pat_reg <= ~frame_in_silence_i;
      end else if (ovf_wake) begin
         pat_reg <= pat_reg;
      end else if (pat_seen) begin
         pat_reg <= xcvr_live;
      end else if (flag_clr) begin
         pat_reg <= 1'b0;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         frm_reg <= 1'b0;
      end else if (frame_wake) begin
         frm_reg <= 1'b1;
      end else if (flag_clr & ~ovf_wake & ~pat_seen) begin
         frm_reg <= 1'b0;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         frame_error_count_reg <= 6'h00;
      end else if (ovf_wake) begin
         frame_error_count_reg <= `CSWM_FRAME_ERROR_COUNT_OVF;
      end else if (flag_clr & ~frame_wake & ~pat_seen) begin
         frame_error_count_reg <= 6'h00;
      end
   end
   // ************
   // interrupt status and mask
   // ************
   // set wins over a same-cycle clear
   genvar g;
   generate
      for (g = 0; g < `CSWM_IRQ_W; g = g + 1) begin : g_irq
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               irq_stat_reg[g] <= 1'b0;
            end else if (irq_ev[g]) begin
               irq_stat_reg[g] <= 1'b1;
            end else if (wr_irq && dat_i[g]) begin
               irq_stat_reg[g] <= 1'b0;
            end
         end
      end
   endgenerate
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_mask_reg <= '0;
      end else if (wr_mask) begin
         irq_mask_reg <= dat_i[`CSWM_IRQ_W-1:0];
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(irq_stat_reg & irq_mask_reg);
      end
   end
   // ************
   // output drive
   // ************
   assign ack_o = ack_reg;
   assign xcvr_mode_o = xcvr_reg;
   assign xcvr_rearm_o = rearm_reg;
   assign sbc_mode_o = sbc_reg;
   assign irq_o = irq_reg;
endmodule

// *** cswm_map.svh ***
// register offsets, field positions, reset values and mode codes of the selective wake mode mapper
`ifndef CSWM_MAP_SVH
`define CSWM_MAP_SVH
`define CSWM_OFF_CTRL 4'h0
`define CSWM_OFF_STAT 4'h4
`define CSWM_OFF_IRQ 4'h8
`define CSWM_OFF_MASK 4'hC
`define CSWM_CODE_OFF0 3'h0
`define CSWM_CODE_WK 3'h1
`define CSWM_CODE_SWK 3'h5
`define CSWM_CODE_OFF1 3'h4
`define CSWM_FRAME_ERROR_COUNT_OVF 6'h20
`define CSWM_IRQ_W 4
`define CSWM_IRQ_WAKE 0
`define CSWM_IRQ_SLEEP 1
`define CSWM_IRQ_RST 2
`define CSWM_IRQ_FS 3
`endif

// *** cswm_pkg.sv ***
// types of the selective wake mode mapper
package cswm_pkg;
   typedef enum logic [2:0] {
      XCVR_OFF, XCVR_WK, XCVR_SWK, XCVR_RXO, XCVR_RXO_SWK, XCVR_NORM, XCVR_NORM_SWK
   } cswm_xcvr_type;
   typedef enum logic [2:0] {
      SBC_NORMAL, SBC_STOP, SBC_SLEEP, SBC_RESTART, SBC_FAILSAFE
   } cswm_sbc_type;
endpackage

// *** cswm_top_assertions.sv ***
// concurrent checks of the selective wake mode mapper
`timescale 1ns/1ns
module cswm_top_assertions (
   // clock, reset and bus
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic ack_o,
   // events and modes
   input wire logic go_failsafe_i,
   input wire logic wake_frame_i,
   input wire logic [2:0] xcvr_mode_o,
   input wire logic xcvr_rearm_o,
   input wire logic [2:0] sbc_mode_o
);
   localparam logic [2:0] DEC [8] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h0, 3'h2, 3'h4, 3'h6};
   wire logic wr = cyc_i & stb_i & ack_o & we_i & sel_i[0] & (adr_i == 4'h0) & (sbc_mode_o == 3'h0);
   wire logic [2:0] sm = sbc_mode_o;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_sleep_set; sm == 3'h2 && $past(sm) == 3'h2 |-> xcvr_mode_o inside {3'h0, 3'h1, 3'h2}; endproperty
   a_sleep_set: assert property (p_sleep_set) else $error("bad sleep mode");
   property p_rearm; sm == 3'h2 && $past(sm) != 3'h2 |-> ##[0:2] xcvr_rearm_o; endproperty
   a_rearm: assert property (p_rearm) else $error("no rearm");
   property p_sleep_hold; sm == 3'h2 && $past(sm) == 3'h2 |-> $stable(xcvr_mode_o); endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("mode moved in sleep");
   property p_restart_set; sm == 3'h3 && $past(sm) == 3'h3 |-> xcvr_mode_o inside {3'h0, 3'h1, 3'h2}; endproperty
   a_restart_set: assert property (p_restart_set) else $error("bad restart mode");
   property p_norm_restart; sm == 3'h3 && $past(sm) == 3'h0 |-> ##[0:1] xcvr_mode_o inside {3'h0, 3'h1}; endproperty
   a_norm_restart: assert property (p_norm_restart) else $error("bad restart from normal");
   property p_frame_wake; sm == 3'h2 && xcvr_mode_o == 3'h2 && wake_frame_i |-> ##[1:2] sm == 3'h3; endproperty
   a_frame_wake: assert property (p_frame_wake) else $error("frame did not wake");
   property p_fs_entry; go_failsafe_i |-> ##[1:2] sm == 3'h4; endproperty
   a_fs_entry: assert property (p_fs_entry) else $error("no fail-safe");
   property p_fs_wk; sm == 3'h4 && $past(sm) == 3'h4 |-> xcvr_mode_o == 3'h1; endproperty
   a_fs_wk: assert property (p_fs_wk) else $error("fail-safe not wake capable");
   property p_decode;
      logic [2:0] c;
      (wr, c = dat_i[2:0]) ##2 sm == 3'h0 |-> xcvr_mode_o == DEC[c] ||
         (c[2] && c[1:0] != 2'h0 && xcvr_mode_o == DEC[{1'b0, c[1:0]}]);
   endproperty
   a_decode: assert property (p_decode) else $error("bad mode decode");
   c_swk: cover property (sm == 3'h2 && xcvr_mode_o == 3'h2);
   c_wake: cover property (sm == 3'h3 && xcvr_mode_o == 3'h2);
   c_fs: cover property (sm == 3'h4);
endmodule
bind cswm_top cswm_top_assertions u_cswm_top_assertions (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
   .dat_i, .ack_o, .go_failsafe_i, .wake_frame_i, .xcvr_mode_o, .xcvr_rearm_o, .sbc_mode_o);

// *** cswm_bus_model.sv ***
// bus side model: turns bench requests into one-cycle wake events
`timescale 1ns/1ns
module cswm_bus_model (
   // clock and request
   input wire logic clk_i,
   input wire logic [2:0] ev_i,
   input wire logic sil_i,
   // wake events
   output logic pat_o,
   output logic frm_o,
   output logic sil_o,
   output logic ovf_o,
   output logic oth_o
);
   always_ff @(posedge clk_i) begin
      pat_o <= ev_i == 3'h1;
      frm_o <= ev_i == 3'h2;
      sil_o <= sil_i;
      ovf_o <= ev_i == 3'h3;
      oth_o <= ev_i == 3'h4;
   end
endmodule

// *** tb_cswm_top.sv ***
// self-checking bench of the selective wake mode mapper
`timescale 1ns/1ns
module tb_cswm_top;
   localparam logic [2:0] DEC [8] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h0, 3'h2, 3'h4, 3'h6};
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic we_i = 1'b0;
   logic sil = 1'b0;
   logic [3:0] adr_i = 4'h0;
   logic [31:0] dat_i = 32'h0000_0000;
   logic [4:0] gp = 5'h00;
   logic [2:0] ev = 3'h0;
   logic [31:0] rd, r;
   logic [27:0] f;
   logic [2:0] c, sx, ek, v;
   logic e, sw;
   int seed = 32'h602a_0a5a;
   int error_cnt = 0;
   int n_tests = 0;
   wire logic [31:0] dat_o;
   wire logic ack_o, irq, wp, wf, fis, eo, ow;
   wire logic [2:0] xm, sm;
   always #10 clk_i = ~clk_i;
   cswm_top u_cswm_top (.clk_i, .rst_i, .cyc_i, .stb_i(cyc_i), .we_i, .adr_i, .sel_i(4'hF), .dat_i, .dat_o, .ack_o,
      .go_normal_i(gp[0]), .go_stop_i(gp[1]), .go_sleep_i(gp[2]), .go_restart_i(gp[3]), .go_failsafe_i(gp[4]),
      .wake_pattern_i(wp), .wake_frame_i(wf), .frame_in_silence_i(fis), .frame_error_count_overflow_i(eo), .other_wake_i(ow),
      .xcvr_mode_o(xm), .xcvr_rearm_o(), .sbc_mode_o(sm), .irq_o(irq));
   cswm_bus_model u_cswm_bus_model (.clk_i, .ev_i(ev), .sil_i(sil), .pat_o(wp), .frm_o(wf), .sil_o(fis), .ovf_o(eo),
      .oth_o(ow));
   // expected status: low half values, high half care mask
   function automatic logic [27:0] fx(input logic [2:0] v, input logic sw, e, s);
      logic [13:0] x, m;
      x = {(v == 3'h3) ? 6'h20 : 6'h00, 1'b0, v == 3'h2, v == 3'h1 || (v == 3'h2 && !s), v != 3'h4, sw && v != 3'h2, 3'h0};
      m = {{6{v == 3'h3}}, 2'h1, !(v == 3'h3 || (v == 3'h4 && sw)), 1'b1, sw || !e, v == 3'h2, 2'h0};
      return {m, x};
   endfunction
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      n_tests++;
      if (s !== x) begin
         error_cnt++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, s, x);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
      int k = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= {24'h00_0000, d};
      @(posedge clk_i);
      while (ack_o !== 1'b1 && k < 20) begin
         @(posedge clk_i);
         k++;
      end
      chk(k < 20, 1'b1);
      rd = dat_o;
      cyc_i <= 1'b0;
   endtask
   // pulse a mode request or wake event, then wait for the system mode
   task automatic go(input logic [4:0] g, input logic [2:0] w, input logic [2:0] m);
      int k = 0;
      @(posedge clk_i);
      gp <= g;
      ev <= w;
      @(posedge clk_i);
      gp <= 5'h00;
      ev <= 3'h0;
      while (sm !== m && k < 9) begin
         @(posedge clk_i);
         k++;
      end
      @(posedge clk_i);
      chk(sm, m);
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      stop_test();
   end
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b1, 4'hC, 8'h02);
      wb(1'b0, 4'h1, 8'h00);
      chk(rd, 32'h0000_0000);
      for (int i = 0; i < 16; i++) begin
         c = i[2:0];
         e = i[3];
         sw = c[2] && c[1:0] != 2'h0;
         sx = (c[1:0] == 2'h0) ? 3'h0 : (sw && !e) ? 3'h2 : 3'h1;
         ek = (c[1:0] == 2'h0) ? c : sw ? 3'h5 : 3'h1;
         if (e) begin
            wb(1'b1, 4'h0, 8'h05);
            go(5'h08, 3'h0, 3'h3);
            chk(xm, 3'h1);
            wb(1'b0, 4'h4, 8'h00);
            chk(rd[3], 1'b1);
            go(5'h01, 3'h0, 3'h0);
         end
         wb(1'b1, 4'h0, 8'h00);
         if (!e) wb(1'b1, 4'h4, 8'h0C);
         wb(1'b1, 4'h0, {5'h00, c});
         wb(1'b0, 4'h0, 8'h00);
         chk(xm, DEC[(e && sw) ? {1'b0, c[1:0]} : c]);
         go(5'h04, 3'h0, 3'h2);
         chk(xm, sx);
         wb(1'b1, 4'h0, {5'h00, ~c});
         wb(1'b0, 4'h0, 8'h00);
         chk(rd[2:0], ek);
         chk(irq, 1'b1);
         wb(1'b1, 4'h8, 8'h0F);
         r = $random(seed);
         sil <= r[1];
         v = (sx == 3'h2) ? (r[0] ? 3'h2 : r[2] ? 3'h3 : 3'h4) : (sx == 3'h1 && r[0]) ? 3'h1 : 3'h4;
         f = fx(v, sw, e, r[1]);
         go(5'h00, v, 3'h3);
         chk(xm, (sx == 3'h0) ? 3'h0 : (v == 3'h2) ? 3'h2 : 3'h1);
         wb(1'b0, 4'h4, 8'h00);
         chk(rd[13:0] & f[27:14], f[13:0]);
         wb(1'b0, 4'h0, 8'h00);
         chk(rd[2:0], ek);
         chk(irq, 1'b0);
         go(5'h01, 3'h0, 3'h0);
         wb(1'b1, 4'h4, 8'h10);
      end
      wb(1'b1, 4'h0, 8'h07);
      go(5'h10, 3'h0, 3'h4);
      chk(xm, 3'h1);
      stop_test();
   end
endmodule
